// ### design/sbg_glue.sv
//////////////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Decode host accesses: 256-byte RAM window, I/O page and 2K ROM window.
// - Write to control location latches bank select bits 0-3; zero means no ROM.
// - Status bit0 ACIA irq, bit1 VIA irq, bit2 shot, bit3 menu button active low.
// - Status bits 5-7 show DSR, CTS, DCD, active high.
// - Firmware ROM mapped as 2K banks in firmware window; select 0 disables.
// - Activity light on while any ROM bank is selected.
// - Large ROM: PIA port B bit 2 is extra high bank bit; code 8 unreachable upper.
// - RAM bank from PIA port A bits 0-5, 0-7, or 0-6 plus port B bit 1 for 64K.
// - Inverting transceiver: SCSI data plain to host, printer data inverted.
// - VIA port B bit0 is SCSI I/O and sets transceiver direction, 1 drives out.
// - VIA port B: C/D, BSY, REQ two-way; SEL, RST outputs only; all active low.
// - Port B bit4 printer busy, bit5 fault; switch forces fault input to one.
// - SCSI REQ to VIA control input A1, ACK from VIA control line A2.
// - Hardware handshake mode drives ACK on each port A access; rest is software.
// - VIA control input B1 pulled low while either button is held.
// - VIA control line B2 drives printer strobe low at least 0.5 us.
// - PIA port B reads graphics, write-protect and switches 2-7, active low.
// - PIA A2 drives RTS, PIA B2 drives DTR, active high; PIA A1, B1 unconnected.
// - PIA register selects wired conventionally: port A, ctrl A, port B, ctrl B.
// - ACIA clocked from its own crystal; its modem pins are unconnected.
// - ACIA served from firmware bank 1, VIA from bank 2.
//////////////////////////////////////////////////////////////////////////////////////////
module sbg_glue (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        reset_n,
   // Host expansion bus
   input  wire logic [15:0] hostAddr,
   input  wire logic        hostRd,
   input  wire logic        hostWr,
   input  wire logic [7:0]  hostWdata,
   output logic      [7:0]  hostRdata,
   output logic             hostRdataOe,
   // Variant straps
   input  wire logic        romLarge,
   input  wire sbg_pkg::sbg_ramsz_t ramSize,
   // Peripheral chip selects and data
   output logic             aciaSel,
   output logic             viaSel,
   output logic             piaSel,
   output logic [1:0]       piaRegSel,
   output logic [3:0]       viaRegSel,
   output logic [1:0]       aciaRegSel,
   input  wire logic [7:0]  aciaRdata,
   input  wire logic [7:0]  viaRdata,
   input  wire logic [7:0]  piaRdata,
   input  wire logic        aciaIrq,
   input  wire logic        viaIrq,
   // ROM and RAM
   output logic             romSel,
   output logic [14:0]      romAddr,
   input  wire logic [7:0]  romRdata,
   output logic             ramSel,
   output logic [15:0]      ramAddr,
   input  wire logic [7:0]  ramRdata,
   output logic             activityLed,
   // VIA ports
   input  wire logic [7:0]  viaPaOut,
   output logic      [7:0]  viaPaIn,
   input  wire logic [7:0]  viaPbOut,
   input  wire logic [7:0]  viaPbDdr,
   output logic      [7:0]  viaPbIn,
   output logic             via_ctrl_input_a1,
   input  wire logic        via_ctrl_line_a2,
   input  wire logic        viaHandshake,
   output logic             via_ctrl_input_b1,
   input  wire logic        via_ctrl_line_b2,
   // PIA ports
   input  wire logic [7:0]  piaPaOut,
   output logic      [7:0]  piaPbIn,
   input  wire logic [7:0]  piaPbOut,
   input  wire logic        piaCa2,
   input  wire logic        piaCb2,
   // SCSI / printer shared data
   input  wire logic [7:0]  scsiDataIn,
   output logic      [7:0]  scsiDataOut,
   output logic             scsiDataOe,
   // SCSI control, active low, open drain
   input  wire logic        scsiIoIn_n,
   input  wire logic        scsiCdIn_n,
   input  wire logic        scsiBsyIn_n,
   input  wire logic        scsiReqIn_n,
   output logic      [3:0]  scsiOeCtl,
   output logic             scsiSelOut_n,
   output logic             scsiRstOut_n,
   output logic             scsiAckOut_n,
   // Printer
   input  wire logic        prnBusy,
   input  wire logic        prnFault_n,
   input  wire logic        faultOverride,
   output logic             prnStrobe_n,
   output logic      [7:0]  prnData,
   output logic             prnValid,
   input  wire logic        prnReady,
   // Switches, buttons, RS-232
   input  wire logic        menuBtn_n,
   input  wire logic        shotBtn_n,
   input  wire logic        gfxSw_n,
   input  wire logic        wpSw_n,
   input  wire logic [7:2]  cfgSw_n,
   input  wire logic        rsDsr,
   input  wire logic        rsCts,
   input  wire logic        rsDcd,
   output logic             rsRts,
   output logic             rsDtr
);

   typedef struct packed {
      logic [3:0]  bank;
      logic [6:0]  strobeCnt;
      logic        strobeLow;
      logic        b2Prev;
      logic [7:0]  statusRd;
      logic [1:0]  bufCnt;
      logic [7:0]  buf0;
      logic [7:0]  buf1;
   } sbg_state_t;

   sbg_state_t st_r, st_nxt;

   //////////////////////////////////////////////////////////////////////////////////////
   // Address decode
   logic       inIo, inRam, inRom, isCtrl, isStat, hostAcc;
   logic [7:0] lo;
   logic [7:0] statusNow;
   logic [2:0] romBank;
   logic       romHi;
   logic       pushPrn, popPrn;

   assign lo      = hostAddr[7:0];
   assign hostAcc = hostRd | hostWr;
   assign inIo    = hostAddr[15:8] == sbg_pkg::IO_PAGE_HI;
   assign inRam   = hostAddr[15:8] == sbg_pkg::RAM_PAGE_HI;
   assign inRom   = hostAddr[15:11] == sbg_pkg::ROM_PAGE_HI && st_r.bank != sbg_pkg::BANK_NONE;
   assign isCtrl  = inIo && lo >= sbg_pkg::CTRL_LO && lo != sbg_pkg::STATUS_OFF;
   assign isStat  = inIo && lo == sbg_pkg::STATUS_OFF;
   assign aciaSel = hostAcc && inIo && lo >= sbg_pkg::ACIA_LO && lo <= sbg_pkg::ACIA_HI;
   assign viaSel  = hostAcc && inIo && lo >= sbg_pkg::VIA_LO && lo <= sbg_pkg::VIA_HI;
   assign piaSel  = hostAcc && inIo && lo >= sbg_pkg::PIA_LO && lo <= sbg_pkg::PIA_HI;
   assign piaRegSel  = lo[1:0];
   assign viaRegSel  = lo[3:0];
   assign aciaRegSel = lo[1:0];

   //////////////////////////////////////////////////////////////////////////////////////
   // ROM and RAM banking
   assign romHi = romLarge & piaPbOut[sbg_pkg::PB_ROM_HI];
   always_comb begin
      case (st_r.bank)
         4'h1:    romBank = 3'h0;
         4'h2:    romBank = 3'h1;
         4'h4:    romBank = 3'h2;
         4'h8:    romBank = 3'h3;
         default: romBank = st_r.bank[2:0];
      endcase
   end
   assign romSel  = hostRd && inRom && !(romHi && st_r.bank == sbg_pkg::BANK_UPPER_NO);
   assign romAddr = {romHi, st_r.bank[3] ? 3'h7 : romBank, hostAddr[10:0]};
   assign activityLed = st_r.bank != sbg_pkg::BANK_NONE;
   assign ramSel  = hostAcc && inRam;
   always_comb begin
      case (ramSize)
         sbg_pkg::SBG_RAM8K:  ramAddr = {2'h0, piaPaOut[5:0], hostAddr[7:0]};
         sbg_pkg::SBG_RAM32K: ramAddr = {piaPaOut, hostAddr[7:0]};
         default:             ramAddr = {piaPbOut[sbg_pkg::PB_RAM_HI], piaPaOut[6:0], hostAddr[7:0]};
      endcase
   end

   //////////////////////////////////////////////////////////////////////////////////////
   // Status and read mux
   assign statusNow = {rsDcd, rsCts, rsDsr, 1'b0, menuBtn_n, shotBtn_n, viaIrq, aciaIrq};
   always_comb begin
      hostRdata   = st_r.statusRd;
      hostRdataOe = 1'b0;
      if (hostRd) begin
         hostRdataOe = 1'b1;
         if (isStat)       hostRdata = statusNow;
         else if (aciaSel) hostRdata = aciaRdata;
         else if (viaSel)  hostRdata = viaRdata;
         else if (piaSel)  hostRdata = piaRdata;
         else if (ramSel)  hostRdata = ramRdata;
         else if (romSel)  hostRdata = romRdata;
         else              hostRdataOe = 1'b0;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////
   // VIA / PIA pin wiring
   assign viaPaIn     = scsiDataIn;
   assign scsiDataOut = viaPaOut;
   assign scsiDataOe  = viaPbOut[sbg_pkg::VB_IO] & viaPbDdr[sbg_pkg::VB_IO];
   assign scsiOeCtl   = {viaPbDdr[sbg_pkg::VB_REQ] & ~viaPbOut[sbg_pkg::VB_REQ],
                         viaPbDdr[sbg_pkg::VB_BSY] & ~viaPbOut[sbg_pkg::VB_BSY],
                         viaPbDdr[sbg_pkg::VB_CD]  & ~viaPbOut[sbg_pkg::VB_CD],
                         viaPbDdr[sbg_pkg::VB_IO]  & ~viaPbOut[sbg_pkg::VB_IO]};
   assign scsiSelOut_n = viaPbOut[sbg_pkg::VB_SEL] | ~viaPbDdr[sbg_pkg::VB_SEL];
   assign scsiRstOut_n = viaPbOut[sbg_pkg::VB_RST] | ~viaPbDdr[sbg_pkg::VB_RST];
   assign viaPbIn = {scsiReqIn_n, scsiBsyIn_n, prnFault_n | faultOverride, prnBusy,
                     scsiRstOut_n, scsiSelOut_n, scsiCdIn_n, scsiIoIn_n};
   assign via_ctrl_input_a1 = scsiReqIn_n;
   assign scsiAckOut_n      = via_ctrl_line_a2 | ~viaHandshake;
   assign via_ctrl_input_b1 = menuBtn_n & shotBtn_n;
   assign prnStrobe_n       = ~st_r.strobeLow;
   assign piaPbIn = {cfgSw_n, wpSw_n, gfxSw_n};
   assign rsRts   = piaCa2;
   assign rsDtr   = piaCb2;

   // Printer byte buffer: captured on strobe start, drained by the printer side
   assign pushPrn  = !via_ctrl_line_b2 && st_r.b2Prev && st_r.bufCnt != 2'd2;
   assign popPrn   = prnValid && prnReady;
   assign prnValid = st_r.bufCnt != 2'd0;
   assign prnData  = st_r.buf0;

   //////////////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      st_nxt = st_r;
      st_nxt.b2Prev = via_ctrl_line_b2;
      if (hostWr && isCtrl) st_nxt.bank = hostWdata[3:0];
      if (hostRd && isStat) st_nxt.statusRd = statusNow;
      if (!via_ctrl_line_b2 && st_r.b2Prev) begin
         st_nxt.strobeLow = 1'b1;
         st_nxt.strobeCnt = sbg_pkg::STROBE_CNT;
      end else if (st_r.strobeCnt != 7'd0) begin
         st_nxt.strobeCnt = st_r.strobeCnt - 7'd1;
      end else begin
         st_nxt.strobeLow = !via_ctrl_line_b2;
      end
      if (popPrn) begin
         st_nxt.buf0   = st_r.buf1;
         st_nxt.bufCnt = st_r.bufCnt - 2'd1;
      end
      if (pushPrn) begin
         if (st_nxt.bufCnt == 2'd0) st_nxt.buf0 = ~viaPaOut;
         else st_nxt.buf1 = ~viaPaOut;
         st_nxt.bufCnt = st_nxt.bufCnt + 2'd1;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= '{bank: sbg_pkg::BANK_RST, strobeCnt: 7'h00, strobeLow: 1'b0, b2Prev: 1'b1,
                   statusRd: 8'h00, bufCnt: 2'h0, buf0: 8'h00, buf1: 8'h00};
      end else begin
         st_r <= st_nxt;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking chk_clk @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);
   chk_bank_latch: assert property (@(posedge clk_sys) disable iff (!reset_n)
      hostWr && isCtrl |=> st_r.bank == $past(hostWdata[3:0])) else $error("bank not latched");
   chk_led_bank: assert property (@(posedge clk_sys) disable iff (!reset_n)
      activityLed == (st_r.bank != 4'h0)) else $error("led mismatch");
   chk_status_bits: assert property (@(posedge clk_sys) disable iff (!reset_n)
      hostRd && isStat |-> hostRdata[1:0] == {viaIrq, aciaIrq} && hostRdata[3] == menuBtn_n)
      else $error("status wrong");
   chk_rs232_bits: assert property (@(posedge clk_sys) disable iff (!reset_n)
      hostRd && isStat |-> hostRdata[7:5] == {rsDcd, rsCts, rsDsr}) else $error("rs232 bits wrong");
   chk_rom_off: assert property (@(posedge clk_sys) disable iff (!reset_n)
      st_r.bank == 4'h0 |-> !romSel) else $error("rom on with bank zero");
   chk_strobe_width: assert property (@(posedge clk_sys) disable iff (!reset_n)
      $fell(prnStrobe_n) |-> !prnStrobe_n [*8]) else $error("strobe too short");
   chk_unused_float: assert property (@(posedge clk_sys) disable iff (!reset_n)
      hostRd && inIo && lo < 8'h20 |-> !hostRdataOe) else $error("unused space driven");
   chk_dir_data: assert property (@(posedge clk_sys) disable iff (!reset_n)
      scsiDataOe |-> viaPbOut[0]) else $error("direction wrong");
   chk_b1_buttons: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !menuBtn_n |-> !via_ctrl_input_b1) else $error("b1 not low");

   chk_decode_pages: assert property (
      hostAcc && !inIo && !inRam |-> !(aciaSel || viaSel || piaSel || ramSel))
      else $error("access decoded outside windows");

   chk_ctrl_undriven: assert property (
      hostRd && isCtrl |-> !hostRdataOe)
      else $error("control location driven on read");

   chk_bank_hold: assert property (
      !(hostWr && isCtrl) |=> st_r.bank == $past(st_r.bank))
      else $error("bank changed without write");

   chk_status_shot: assert property (
      hostRd && isStat |-> hostRdata[2] == shotBtn_n)
      else $error("shot button bit wrong");

   chk_rom_map: assert property (
      romSel && st_r.bank == 4'h4 |-> romAddr[13:0] == {3'h2, hostAddr[10:0]})
      else $error("rom bank map wrong");

   chk_rom_irq_banks: assert property (
      romSel && st_r.bank inside {4'h1, 4'h2} |-> romAddr[13:11] == {2'h0, st_r.bank[1]})
      else $error("irq bank map wrong");

   chk_rom_upper: assert property (
      romHi && st_r.bank == sbg_pkg::BANK_UPPER_NO |-> !romSel)
      else $error("upper bank code 8 reachable");

   chk_ram_offset: assert property (
      ramSel |-> ramAddr[7:0] == hostAddr[7:0])
      else $error("ram offset wrong");

   chk_ram_bank: assert property (
      ramSel && ramSize == sbg_pkg::SBG_RAM8K |-> ramAddr[15:8] == {2'h0, piaPaOut[5:0]})
      else $error("small ram bank wrong");

   chk_ram_wide: assert property (
      ramSel && ramSize == sbg_pkg::SBG_RAM64K |-> ramAddr[15] == piaPbOut[1])
      else $error("large ram bank bit wrong");

   chk_scsi_data: assert property (
      viaPaIn == scsiDataIn && scsiDataOut == viaPaOut)
      else $error("scsi data path wrong");

   chk_prn_invert: assert property (
      pushPrn && st_r.bufCnt == 2'h0 |=> prnData == ~$past(viaPaOut))
      else $error("printer data not inverted");

   chk_scsi_dir: assert property (
      scsiDataOe == (viaPbOut[0] && viaPbDdr[0]))
      else $error("transceiver direction wrong");

   chk_req_pull: assert property (
      viaPbDdr[7] && !viaPbOut[7] |-> scsiOeCtl[3])
      else $error("req line not pulled");

   chk_sel_out: assert property (
      viaPbDdr[2] |-> scsiSelOut_n == viaPbOut[2])
      else $error("sel line wrong");

   chk_fault_force: assert property (
      faultOverride |-> viaPbIn[5])
      else $error("fault not forced");

   chk_req_a1: assert property (
      via_ctrl_input_a1 == scsiReqIn_n)
      else $error("req not on a1");

   chk_ack_auto: assert property (
      viaHandshake |-> scsiAckOut_n == via_ctrl_line_a2)
      else $error("ack not from a2");

   chk_b1_shot: assert property (
      !shotBtn_n |-> !via_ctrl_input_b1)
      else $error("b1 not low for shot");

   chk_strobe_hold: assert property (
      !prnStrobe_n && st_r.strobeCnt != 7'h00 |=> !prnStrobe_n)
      else $error("strobe released early");

   chk_strobe_load: assert property (
      $fell(prnStrobe_n) |-> st_r.strobeCnt == sbg_pkg::STROBE_CNT)
      else $error("strobe count not loaded");

   chk_pia_switches: assert property (
      piaPbIn == {cfgSw_n, wpSw_n, gfxSw_n})
      else $error("switch inputs wrong");

   chk_rs232_out: assert property (
      rsRts == piaCa2 && rsDtr == piaCb2)
      else $error("rts dtr wrong");

   chk_pia_regsel: assert property (
      piaSel |-> piaRegSel == hostAddr[1:0])
      else $error("pia register select wrong");

   cov_rom_on: cover property (@(posedge clk_sys) hostRd && romSel);
   cov_strobe: cover property (@(posedge clk_sys) $rose(prnStrobe_n));
   cov_buf_full: cover property (@(posedge clk_sys) st_r.bufCnt == 2'd2);
   cov_ram_wide: cover property (@(posedge clk_sys) ramSel && ramSize == sbg_pkg::SBG_RAM64K);
   cov_mid_strobe: cover property (@(posedge clk_sys) pushPrn && st_r.bufCnt == 2'h1);

endmodule : sbg_glue

// ### design/sbg_pkg.sv
package sbg_pkg;
   // Host window decode, 16-bit host addresses
   localparam logic [15:0] IO_PAGE_BASE   = 16'hD100;
   localparam logic [7:0]  IO_PAGE_HI     = 8'hD1;
   localparam logic [7:0]  RAM_PAGE_HI    = 8'hD6;
   localparam logic [15:0] ROM_BASE       = 16'hD800;
   localparam logic [4:0]  ROM_PAGE_HI    = 5'h1B;
   localparam logic [7:0]  ACIA_LO        = 8'h20;
   localparam logic [7:0]  ACIA_HI        = 8'h3F;
   localparam logic [7:0]  VIA_LO         = 8'h40;
   localparam logic [7:0]  VIA_HI         = 8'h7F;
   localparam logic [7:0]  PIA_LO         = 8'h80;
   localparam logic [7:0]  PIA_HI         = 8'hBF;
   localparam logic [7:0]  CTRL_LO        = 8'hC0;
   localparam logic [7:0]  STATUS_OFF     = 8'hFF;
   // Register addresses
   localparam logic [15:0] BANK_SEL_CTRL_ADDR = 16'hD1C0;
   localparam logic [15:0] IRQ_BTN_STAT_ADDR  = 16'hD1FF;
   // Status bit positions
   localparam int ST_ACIA  = 0;
   localparam int ST_VIA   = 1;
   localparam int ST_SHOT  = 2;
   localparam int ST_MENU  = 3;
   localparam int ST_DSR   = 5;
   localparam int ST_CTS   = 6;
   localparam int ST_DCD   = 7;
   // Control field
   localparam int          BANK_W        = 4;
   localparam logic [3:0]  BANK_NONE     = 4'h0;
   localparam logic [3:0]  BANK_RST      = 4'h0;
   localparam logic [3:0]  BANK_UPPER_NO = 4'h8;
   // PIA bit positions
   localparam int PB_ROM_HI = 2;
   localparam int PB_RAM_HI = 1;
   // VIA port B bit positions
   localparam int VB_IO  = 0;
   localparam int VB_CD  = 1;
   localparam int VB_SEL = 2;
   localparam int VB_RST = 3;
   localparam int VB_PBUSY = 4;
   localparam int VB_PFLT  = 5;
   localparam int VB_BSY = 6;
   localparam int VB_REQ = 7;
   // Printer strobe: least low time
   localparam int STROBE_MIN_NS  = 500;
   localparam int CLK_PERIOD_NS  = 10;
   localparam int STROBE_CYCLES  = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [6:0] STROBE_CNT = 7'(STROBE_CYCLES);
   // Memory size variants
   typedef enum logic [1:0] {SBG_RAM8K, SBG_RAM32K, SBG_RAM64K} sbg_ramsz_t;
endpackage : sbg_pkg

// ### dv/sbg_host_model.sv
module sbg_host_model (
   // Bus clock
   input  wire logic        clk_sys,
   // Host expansion bus
   output logic      [15:0] hostAddr,
   output logic             hostRd,
   output logic             hostWr,
   output logic      [7:0]  hostWdata
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      hostAddr  = 16'h0000;
      hostRd    = 1'b0;
      hostWr    = 1'b0;
      hostWdata = 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // One access per strobe, held across the sampling edge, then a moved address
   task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      hostAddr  = a;
      hostWdata = d;
      hostRd    = !wr;
      hostWr    = wr;
      @(negedge clk_sys);
      hostRd    = 1'b0;
      hostWr    = 1'b0;
      hostAddr  = ~a;
      hostWdata = ~d;
   endtask : acc
endmodule : sbg_host_model

// ### dv/test_sbg_glue.sv
module test_scsi_printer_serial_expansion_glue;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [7:0] d; logic [7:0] m; logic oe;} sbg_exp_t;
   logic [15:0]         hostAddr, ramAddr;
   logic [14:0]         romAddr;
   logic [7:0]          hostWdata, hostRdata, aciaRdata, viaRdata, piaRdata, romRdata, ramRdata, viaPaOut, viaPaIn;
   logic [7:0]          viaPbOut, viaPbDdr, viaPbIn, piaPaOut, piaPbIn, piaPbOut, scsiDataIn, scsiDataOut, prnData;
   logic [7:2]          cfgSw_n;
   logic [3:0]          viaRegSel, scsiOeCtl;
   logic [1:0]          piaRegSel, aciaRegSel;
   logic                clk_sys, reset_n, hostRd, hostWr, hostRdataOe, romLarge, aciaSel, viaSel, piaSel, aciaIrq;
   logic                viaIrq, romSel, ramSel, activityLed, via_ctrl_input_a1, via_ctrl_line_a2, viaHandshake;
   logic                via_ctrl_input_b1, via_ctrl_line_b2, piaCa2, piaCb2, scsiDataOe, scsiIoIn_n, scsiCdIn_n;
   logic                scsiBsyIn_n, scsiReqIn_n, scsiSelOut_n, scsiRstOut_n, scsiAckOut_n, prnBusy, prnFault_n;
   logic                faultOverride, prnStrobe_n, prnValid, prnReady, menuBtn_n, shotBtn_n, gfxSw_n, wpSw_n;
   logic                rsDsr, rsCts, rsDcd, rsRts, rsDtr;
   sbg_pkg::sbg_ramsz_t ramSize;
   sbg_exp_t            expQ[$];
   sbg_exp_t            e;
   logic [7:0]          prnQ[$];
   logic [10:0]         o;
   int                  err_total, samples_checked, w, dummy;

   // Memories answer with part of their address so the mapping shows in read data
   assign romRdata = romAddr[14:7];
   assign ramRdata = ramAddr[15:8];

   sbg_glue i_dut (.*);
   sbg_host_model i_host (.clk_sys(clk_sys), .hostAddr(hostAddr), .hostRd(hostRd), .hostWr(hostWr),
                          .hostWdata(hostWdata));

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] x);
      samples_checked++;
      if (s !== x) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", n, x, s);
      end
   endtask : chk

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : print_verdict

   task automatic rd(input logic [15:0] a, input logic [7:0] d, input logic [7:0] m, input logic oe);
      expQ.push_back('{d, m, oe});
      i_host.acc(1'b0, a, 8'h00);
   endtask : rd

   task automatic rnd();
      {aciaIrq, viaIrq, menuBtn_n, shotBtn_n, rsDsr, rsCts, rsDcd, prnBusy, prnFault_n, faultOverride, gfxSw_n,
       wpSw_n, cfgSw_n, scsiIoIn_n, scsiCdIn_n, scsiBsyIn_n, scsiReqIn_n, piaCa2, piaCb2, via_ctrl_line_a2,
       viaHandshake} = 26'($urandom);
      {aciaRdata, viaRdata, piaRdata, scsiDataIn} = $urandom;
      {viaPbOut, viaPbDdr, piaPaOut, piaPbOut} = $urandom | 32'h000C_0000;
      viaPaOut = 8'($urandom);
   endtask : rnd

   task automatic wir();
      #1;
      chk("scsiDataOe", scsiDataOe, viaPbDdr[0] & viaPbOut[0]);
      chk("scsiOeCtl", scsiOeCtl, {viaPbDdr[7:6], viaPbDdr[1:0]} & ~{viaPbOut[7:6], viaPbOut[1:0]});
      chk("scsiSelRst", {scsiSelOut_n, scsiRstOut_n}, {viaPbOut[2], viaPbOut[3]});
      chk("viaPbIn", viaPbIn, {scsiReqIn_n, scsiBsyIn_n, prnFault_n | faultOverride, prnBusy, viaPbOut[3:2],
                               scsiCdIn_n, scsiIoIn_n});
      chk("viaPaIn", viaPaIn, scsiDataIn);
      chk("scsiDataOut", scsiDataOut, viaPaOut);
      chk("viaCtrlIn", {via_ctrl_input_a1, via_ctrl_input_b1}, {scsiReqIn_n, menuBtn_n & shotBtn_n});
      chk("piaPbIn", piaPbIn, {cfgSw_n, wpSw_n, gfxSw_n});
      chk("rsOut", {rsRts, rsDtr}, {piaCa2, piaCb2});
      if (viaHandshake) chk("scsiAck", scsiAckOut_n, via_ctrl_line_a2);
   endtask : wir

   ////////////////////////////////////////////////////////////////////////////////
   // Read monitor and printer monitor
   always @(posedge clk_sys) begin
      if (hostRd) begin
         if (expQ.size() == 0) begin
            chk("extraRead", 8'h01, 8'h00);
         end else begin
            e = expQ.pop_front();
            chk("hostRdataOe", hostRdataOe, e.oe);
            if (e.oe) chk("hostRdata", hostRdata & e.m, e.d & e.m);
            if (piaSel) chk("piaRegSel", piaRegSel, hostAddr[1:0]);
            if (aciaSel) chk("aciaRegSel", aciaRegSel, hostAddr[1:0]);
            if (viaSel) chk("viaRegSel", viaRegSel, hostAddr[3:0]);
         end
      end
      if (prnValid && prnReady) chk("prnData", prnData, prnQ.size() ? prnQ.pop_front() : ~prnData);
   end

   initial begin
      repeat (20000) @(posedge clk_sys);
      err_total++;
      $display("ERROR timeout expected end seen hang");
      print_verdict();
   end

   initial begin
      dummy = $urandom(76);
      reset_n = 1'b0;
      romLarge = 1'b0;
      ramSize = sbg_pkg::SBG_RAM8K;
      viaPaOut = 8'h00;
      via_ctrl_line_b2 = 1'b1;
      prnReady = 1'b1;
      rnd();
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      reset_n = 1'b1;
      #1 chk("resetState", {activityLed, prnStrobe_n, prnValid}, 8'h02);
      repeat (4) begin
         @(negedge clk_sys);
         rnd();
         wir();
         rd(16'hD1FF, {rsDcd, rsCts, rsDsr, 1'b0, menuBtn_n, shotBtn_n, viaIrq, aciaIrq}, 8'hEF, 1'b1);
         rd(16'hD100 + 16'($urandom % 32), 8'h00, 8'h00, 1'b0);
         rd(16'hD200, 8'h00, 8'h00, 1'b0);
         rd(16'hD1C0, 8'h00, 8'h00, 1'b0);
         rd(16'hD120 + 16'($urandom % 32), aciaRdata, 8'hFF, 1'b1);
         rd(16'hD160 + 16'($urandom % 32), viaRdata, 8'hFF, 1'b1);
         rd(16'hD180 + 16'($urandom % 64), piaRdata, 8'hFF, 1'b1);
      end
      $display("test decode done");
      for (int c = 0; c < 16; c++) begin
         i_host.acc(1'b1, 16'hD1C0 + 16'(c), {4'($urandom), 4'(c)});
         chk("activityLed", activityLed, c != 0);
         o = 11'($urandom);
         rd(16'hD800 + 16'(o), {1'b0, 3'(c >> 1), o[10:7]}, (c == 1 || c == 2 || c == 4) ? 8'hFF : 8'h0F, c != 0);
      end
      romLarge = 1'b1;
      piaPbOut[2] = 1'b1;
      i_host.acc(1'b1, 16'hD1C8, 8'h08);
      rd(16'hD800, 8'h00, 8'h00, 1'b0);
      i_host.acc(1'b1, 16'hD1C1, 8'h01);
      rd(16'hD800, 8'h80, 8'h80, 1'b1);
      reset_n = 1'b0;
      @(negedge clk_sys);
      reset_n = 1'b1;
      chk("midReset", {activityLed, prnStrobe_n, prnValid}, 8'h02);
      rd(16'hD800, 8'h00, 8'h00, 1'b0);
      romLarge = 1'b0;
      $display("test rom banks done");
      for (int s = 0; s < 3; s++) begin
         ramSize = sbg_pkg::sbg_ramsz_t'(s);
         piaPaOut = 8'($urandom);
         rd(16'hD600 + 16'($urandom % 256), s == 2 ? {piaPbOut[1], piaPaOut[6:0]} : piaPaOut,
            s == 0 ? 8'h3F : 8'hFF, 1'b1);
      end
      $display("test ram window done");
      prnReady = 1'b0;
      for (int k = 0; k < 3; k++) begin
         viaPaOut = 8'($urandom);
         if (k < 2) prnQ.push_back(~viaPaOut);
         via_ctrl_line_b2 = 1'b0;
         @(negedge clk_sys);
         via_ctrl_line_b2 = 1'b1;
         w = 0;
         repeat (80) begin
            @(negedge clk_sys);
            if (prnStrobe_n === 1'b0) w++;
         end
         chk("strobeLow", (w >= 50) && prnStrobe_n, 1'b1);
      end
      chk("prnValid", prnValid, 1'b1);
      prnReady = 1'b1;
      for (w = 0; w < 20 && prnQ.size() != 0; w++) @(negedge clk_sys);
      chk("prnDrained", {prnQ.size() == 0, prnValid, expQ.size() == 0}, 8'h05);
      $display("test printer done");
      print_verdict();
   end
endmodule : test_scsi_printer_serial_expansion_glue
